// ---- src/operand_type_unpacker.sv ----
// Operand type checker and immediate unpacker for the vector execution unit.
// Assumes requests come from the decoder on core_clk; one answer per request, one cycle later.
//
// Overview of operation
// - Words even addresses, doublewords divisible by four
// - Groups align to eight, sixteen, thirty-two
// - Nibble never accessed as standalone element
// - Signed integers are two's complement
// - Signed nibble vector: eight elements, sign bit three
// - Signed nibbles sign-extend into eight words
// - Unsigned nibbles zero-extend into eight words
// - Packed vector types only as immediate sources
// - Packed byte destination only for raw move
// - Single float: sign, 8 exponent, 23 fraction
// - Double float: sign, 11 exponent, 52 fraction
// - Single precision mode chosen by control bit
// - Alternative mode uses no inf, denormal, NaN
// - IEEE single mode flushes denormals to zero
// - Double only IEEE; denorm bit keeps or flushes
// - Sign-magnitude floats; no 80-bit format
// - Restricted float: sign 7, exponent 6:4, fraction
// - Exponent rebias by adding 124
// - Codes 0x00 and 0x80 give signed zero
// - Zero exponent keeps implied one, min 0.125
// - Restricted float has no inf, NaN, denormal
// - Float mode from control register zero bit 0
`timescale 1ns/10ps
module operand_type_unpacker
    import otu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input otu_req_t req,
    input wire logic [CTRL_ZERO_W-1:0] controlRegisterZero,
    output otu_resp_t resp
);
    otu_resp_t st;
    otu_resp_t next_st;
    logic alternativeMode;
    logic dpKeepDenorm;
    logic [RF_CNT-1:0][SP_W-1:0] rfSingle;

    assign alternativeMode = controlRegisterZero[CTRL_ZERO_FP_MODE_BIT];
    assign dpKeepDenorm = controlRegisterZero[CTRL_ZERO_DP_DENORM_BIT];

    function automatic logic otuIsPacked(input otu_type_t t);
        return t == TYPE_PACKED_SIGNED_NIBBLE_VECTOR || t == TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR ||
            t == TYPE_PACKED_RESTRICTED_FLOAT_VECTOR;
    endfunction

    function automatic logic otuIsByte(input otu_type_t t);
        return t == TYPE_UNSIGNED_BYTE || t == TYPE_SIGNED_BYTE;
    endfunction

    function automatic logic [ADDR_W-1:0] otuAlignMask(input otu_type_t t, input otu_group_t g);
        logic [ADDR_W-1:0] m;
        m = '0;
        case (t)
            TYPE_UNSIGNED_WORD, TYPE_SIGNED_WORD: begin
                m = ALIGN_WORD;
            end
            TYPE_UNSIGNED_DOUBLEWORD, TYPE_SIGNED_DOUBLEWORD, TYPE_SINGLE_FLOAT,
            TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR, TYPE_PACKED_SIGNED_NIBBLE_VECTOR,
            TYPE_PACKED_RESTRICTED_FLOAT_VECTOR: begin
                m = ALIGN_DWORD;
            end
            TYPE_DOUBLE_PRECISION_FLOAT: begin
                m = ALIGN_QWORD;
            end
            default: begin
                m = '0;
            end
        endcase
        case (g)
            GROUP_QUADWORD: begin
                m = m | ALIGN_QWORD;
            end
            GROUP_DOUBLE_QUADWORD: begin
                m = m | ALIGN_DQWORD;
            end
            GROUP_QUAD_QUADWORD: begin
                m = m | ALIGN_QQWORD;
            end
            default: begin
                m = m;
            end
        endcase
        return m;
    endfunction

    function automatic logic otuSingleDenorm(input logic [SP_W-1:0] v);
        return v[SP_FRAC_W +: SP_EXP_W] == '0 && v[0 +: SP_FRAC_W] != '0;
    endfunction

    function automatic logic otuSingleSpecial(input logic [SP_W-1:0] v);
        return &v[SP_FRAC_W +: SP_EXP_W];
    endfunction

    function automatic logic otuDoubleDenorm(input logic [DP_W-1:0] v);
        return v[DP_FRAC_W +: DP_EXP_W] == '0 && v[0 +: DP_FRAC_W] != '0;
    endfunction

    for (genvar i = 0; i < RF_CNT; i++) begin : g_rf
        otu_rf_to_single u_rf (
            .rfCode(req.operand[i*RF_W +: RF_W]),
            .single(rfSingle[i])
        );
    end

    always_comb begin
        next_st = '0;
        next_st.valid = req.valid;
        if (req.valid) begin
            next_st.err.nibbleAlone = req.opType == TYPE_NIBBLE;
            next_st.err.packedNotImm = otuIsPacked(req.opType) && req.role != ROLE_IMMEDIATE;
            next_st.err.packedByteDst = req.role == ROLE_DESTINATION && otuIsByte(req.opType) && !req.rawMove;
            if (req.role != ROLE_IMMEDIATE && req.opType != TYPE_NIBBLE) begin
                next_st.err.misaligned = |(req.addr & otuAlignMask(req.opType, req.group));
            end
            if (req.rawMove && !otuIsPacked(req.opType)) begin
                // Raw move copies bits untouched, no flush or extension
                next_st.data[DP_W-1:0] = req.operand;
            end else begin
                case (req.opType)
                    TYPE_PACKED_SIGNED_NIBBLE_VECTOR: begin
                        for (int i = 0; i < NIB_CNT; i++) begin
                            next_st.data[i*WORD_W +: WORD_W] = {{(WORD_W-NIB_W){req.operand[i*NIB_W+NIB_SIGN_BIT]}},
                                req.operand[i*NIB_W +: NIB_W]};
                        end
                    end
                    TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR: begin
                        for (int i = 0; i < NIB_CNT; i++) begin
                            next_st.data[i*WORD_W +: WORD_W] = {{(WORD_W-NIB_W){1'b0}}, req.operand[i*NIB_W +: NIB_W]};
                        end
                    end
                    TYPE_PACKED_RESTRICTED_FLOAT_VECTOR: begin
                        next_st.data[RF_CNT*SP_W-1:0] = rfSingle;
                    end
                    TYPE_SIGNED_BYTE: begin
                        next_st.data[DP_W-1:0] = DP_W'($signed(req.operand[RF_W-1:0]));
                    end
                    TYPE_SIGNED_WORD: begin
                        next_st.data[DP_W-1:0] = DP_W'($signed(req.operand[WORD_W-1:0]));
                    end
                    TYPE_SIGNED_DOUBLEWORD: begin
                        next_st.data[DP_W-1:0] = DP_W'($signed(req.operand[SP_W-1:0]));
                    end
                    TYPE_UNSIGNED_BYTE: begin
                        next_st.data[RF_W-1:0] = req.operand[RF_W-1:0];
                    end
                    TYPE_UNSIGNED_WORD: begin
                        next_st.data[WORD_W-1:0] = req.operand[WORD_W-1:0];
                    end
                    TYPE_UNSIGNED_DOUBLEWORD: begin
                        next_st.data[SP_W-1:0] = req.operand[SP_W-1:0];
                    end
                    TYPE_SINGLE_FLOAT: begin
                        next_st.data[SP_W-1:0] = req.operand[SP_W-1:0];
                        next_st.err.alternativeEncoding = alternativeMode && otuSingleSpecial(req.operand[SP_W-1:0]);
                        if (otuSingleDenorm(req.operand[SP_W-1:0])) begin
                            next_st.data[SP_W-2:0] = '0;
                        end
                    end
                    TYPE_DOUBLE_PRECISION_FLOAT: begin
                        next_st.data[DP_W-1:0] = req.operand;
                        next_st.err.modeUnsupported = alternativeMode;
                        if (!dpKeepDenorm && otuDoubleDenorm(req.operand)) begin
                            next_st.data[DP_W-2:0] = '0;
                        end
                    end
                    default: begin
                        next_st.data = '0;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign resp = st;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    sequence sImmReq(otu_type_t t);
        req.valid && req.role == ROLE_IMMEDIATE && !req.rawMove && req.opType == t;
    endsequence

    sequence sMemReq;
        req.valid && req.role != ROLE_IMMEDIATE;
    endsequence

    chk_signed_nibble_ext: assert property (
        sImmReq(TYPE_PACKED_SIGNED_NIBBLE_VECTOR) |=> resp.valid &&
        resp.data[127:112] == {{12{$past(req.operand[31])}}, $past(req.operand[31:28])} &&
        resp.data[15:0] == {{12{$past(req.operand[3])}}, $past(req.operand[3:0])})
        else $error("signed nibble lane wrong");

    chk_unsigned_nibble_ext: assert property (
        sImmReq(TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR) |=> resp.data[111:96] == {12'h000, $past(req.operand[27:24])})
        else $error("unsigned nibble lane wrong");

    chk_rf_neg_zero: assert property (
        sImmReq(TYPE_PACKED_RESTRICTED_FLOAT_VECTOR) ##0 (req.operand[15:8] == RF_ZERO_NEG)
        |=> resp.data[63:32] == 32'h80000000)
        else $error("restricted negative zero wrong");

    chk_rf_small_exp: assert property (
        sImmReq(TYPE_PACKED_RESTRICTED_FLOAT_VECTOR) ##0 (req.operand[6:4] == 3'h0 && req.operand[3:0] != 4'h0)
        |=> resp.data[30:23] == 8'h7c && resp.data[22:19] == $past(req.operand[3:0]))
        else $error("restricted small value wrong");

    chk_rf_top_exp: assert property (
        sImmReq(TYPE_PACKED_RESTRICTED_FLOAT_VECTOR) ##0 (req.operand[30:28] == 3'h7)
        |=> resp.data[126:119] == 8'h83)
        else $error("restricted exponent rebias wrong");

    chk_word_align: assert property (
        sMemReq and (req.opType == TYPE_SIGNED_WORD && req.addr[0]) |=> resp.err.misaligned)
        else $error("odd word address not flagged");

    chk_group_align: assert property (
        sMemReq and (req.group == GROUP_QUAD_QUADWORD && req.opType == TYPE_UNSIGNED_BYTE) |=>
        resp.err.misaligned == ($past(req.addr[4:0]) != 5'h00))
        else $error("group alignment wrong");

    chk_packed_role: assert property (
        sMemReq and (req.opType == TYPE_PACKED_RESTRICTED_FLOAT_VECTOR) |=> resp.err.packedNotImm)
        else $error("packed source not refused");

    chk_byte_dst: assert property (
        req.valid && req.role == ROLE_DESTINATION && req.opType == TYPE_UNSIGNED_BYTE
        |=> resp.err.packedByteDst == !$past(req.rawMove))
        else $error("packed byte destination wrong");

    chk_single_flush: assert property (
        sImmReq(TYPE_SINGLE_FLOAT) ##0 (req.operand[30:23] == 8'h00)
        |=> resp.data[30:0] == 31'h00000000 && resp.data[31] == $past(req.operand[31]))
        else $error("single denormal not flushed");

    chk_double_mode: assert property (
        sImmReq(TYPE_DOUBLE_PRECISION_FLOAT) ##0 (controlRegisterZero[CTRL_ZERO_DP_DENORM_BIT])
        |=> resp.data[63:0] == $past(req.operand) && resp.err.modeUnsupported == $past(alternativeMode))
        else $error("double denormal handling wrong");

    chk_alone_nibble: assert property (
        req.valid && req.opType == TYPE_NIBBLE |=> resp.err.nibbleAlone && !resp.err.misaligned)
        else $error("standalone nibble not refused");

    // Answer one edge after every taken request; silence otherwise is checked by chk_no_spurious
    chk_answer_timing: assert property (
        req.valid |=> resp.valid)
        else $error("answer missing after request");

    chk_no_spurious: assert property (
        !req.valid |=> !resp.valid && resp.err == '0 && resp.data == '0)
        else $error("answer without request");

    chk_dword_align: assert property (
        sMemReq ##0 (req.opType == TYPE_UNSIGNED_DOUBLEWORD && req.group == GROUP_NONE)
        |=> resp.err.misaligned == ($past(req.addr[1:0]) != 2'h0))
        else $error("doubleword alignment wrong");

    chk_signed_byte: assert property (
        sImmReq(TYPE_SIGNED_BYTE)
        |=> resp.data[63:8] == {56{$past(req.operand[7])}} && resp.data[7:0] == $past(req.operand[7:0]))
        else $error("signed byte widening wrong");

    chk_raw_copy: assert property (
        req.valid && req.rawMove && req.opType == TYPE_UNSIGNED_BYTE
        |=> resp.data[63:0] == $past(req.operand) && resp.data[127:64] == 64'h0)
        else $error("raw move data altered");

    // special codes flagged only in alternative mode
    chk_special_code: assert property (
        sImmReq(TYPE_SINGLE_FLOAT)
        |=> resp.err.alternativeEncoding == ($past(alternativeMode) && $past(req.operand[30:23]) == 8'hff))
        else $error("special code flag wrong");

    chk_double_flush: assert property (
        sImmReq(TYPE_DOUBLE_PRECISION_FLOAT) ##0 (!dpKeepDenorm && req.operand[62:52] == 11'h000)
        |=> resp.data[62:0] == 63'h0 && resp.data[63] == $past(req.operand[63]))
        else $error("double denormal not flushed");

    // lane two sign from operand bit 23
    chk_rf_lane_order: assert property (
        sImmReq(TYPE_PACKED_RESTRICTED_FLOAT_VECTOR) |=> resp.data[95] == $past(req.operand[23]))
        else $error("restricted lane order wrong");

    // lanes finite; lane 0 zero exponent only for zero codes
    chk_rf_finite_only: assert property (
        sImmReq(TYPE_PACKED_RESTRICTED_FLOAT_VECTOR)
        |=> resp.data[30:23] != 8'hff && resp.data[62:55] != 8'hff &&
        resp.data[94:87] != 8'hff && resp.data[126:119] != 8'hff &&
        (resp.data[30:23] == 8'h00) == ($past(req.operand[6:0]) == 7'h00))
        else $error("restricted lane not finite");
endmodule

// ---- src/otu_pkg.sv ----
// Constants, encodings and carrier types for the operand type unpacker.
// Assumes a single 250 MHz execution-unit clock shared by all users of the package.
package otu_pkg;

    // Operand and vector widths
    localparam int IMM_W = 32;
    localparam int ADDR_W = 16;
    localparam int CTRL_ZERO_W = 32;
    localparam int NIB_W = 4;
    localparam int NIB_CNT = 8;
    localparam int NIB_SIGN_BIT = 3;
    localparam int WORD_W = 16;
    localparam int VEC_W = 128;

    // Restricted 8-bit float layout
    localparam int RF_W = 8;
    localparam int RF_CNT = 4;
    localparam int RF_SIGN_BIT = 7;
    localparam int RF_EXP_LSB = 4;
    localparam int RF_EXP_W = 3;
    localparam int RF_FRAC_W = 4;
    localparam logic [RF_W-1:0] RF_ZERO_POS = 8'h00;
    localparam logic [RF_W-1:0] RF_ZERO_NEG = 8'h80;

    // Single and double precision layouts
    localparam int SP_W = 32;
    localparam int SP_EXP_W = 8;
    localparam int SP_FRAC_W = 23;
    localparam int DP_W = 64;
    localparam int DP_EXP_W = 11;
    localparam int DP_FRAC_W = 52;

    // Control register zero bit positions
    localparam int CTRL_ZERO_FP_MODE_BIT = 0;
    localparam int CTRL_ZERO_DP_DENORM_BIT = 6;

    // Byte address masks for natural boundaries
    localparam logic [ADDR_W-1:0] ALIGN_WORD = 16'h0001;
    localparam logic [ADDR_W-1:0] ALIGN_DWORD = 16'h0003;
    localparam logic [ADDR_W-1:0] ALIGN_QWORD = 16'h0007;
    localparam logic [ADDR_W-1:0] ALIGN_DQWORD = 16'h000f;
    localparam logic [ADDR_W-1:0] ALIGN_QQWORD = 16'h001f;

    typedef enum logic [3:0] {
        TYPE_UNSIGNED_BYTE,
        TYPE_SIGNED_BYTE,
        TYPE_UNSIGNED_WORD,
        TYPE_SIGNED_WORD,
        TYPE_UNSIGNED_DOUBLEWORD,
        TYPE_SIGNED_DOUBLEWORD,
        TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR,
        TYPE_PACKED_SIGNED_NIBBLE_VECTOR,
        TYPE_SINGLE_FLOAT,
        TYPE_DOUBLE_PRECISION_FLOAT,
        TYPE_PACKED_RESTRICTED_FLOAT_VECTOR,
        TYPE_NIBBLE
    } otu_type_t;

    typedef enum logic [1:0] {
        ROLE_IMMEDIATE,
        ROLE_SOURCE,
        ROLE_DESTINATION
    } otu_role_t;

    typedef enum logic [1:0] {
        GROUP_NONE,
        GROUP_QUADWORD,
        GROUP_DOUBLE_QUADWORD,
        GROUP_QUAD_QUADWORD
    } otu_group_t;

    typedef struct packed {
        logic valid;
        otu_type_t opType;
        otu_role_t role;
        otu_group_t group;
        logic rawMove;
        logic [ADDR_W-1:0] addr;
        logic [DP_W-1:0] operand;
    } otu_req_t;

    typedef struct packed {
        logic misaligned;
        logic nibbleAlone;
        logic packedNotImm;
        logic packedByteDst;
        logic alternativeEncoding;
        logic modeUnsupported;
    } otu_err_t;

    typedef struct packed {
        logic valid;
        otu_err_t err;
        logic [VEC_W-1:0] data;
    } otu_resp_t;

endpackage

// ---- src/otu_rf_to_single.sv ----
// Combinational widening of one restricted 8-bit float to single precision.
// Assumes the caller registers the result; no clock inside.
`timescale 1ns/10ps
module otu_rf_to_single
    import otu_pkg::*;
(
    input wire logic [RF_W-1:0] rfCode,
    output logic [SP_W-1:0] single
);
    logic [RF_EXP_W-1:0] exp3;
    logic [RF_FRAC_W-1:0] frac4;
    logic sign;

    assign sign = rfCode[RF_SIGN_BIT];
    assign exp3 = rfCode[RF_EXP_LSB +: RF_EXP_W];
    assign frac4 = rfCode[0 +: RF_FRAC_W];

    always_comb begin
        single = '0;
        single[SP_W-1] = sign;
        if (rfCode == RF_ZERO_POS || rfCode == RF_ZERO_NEG) begin
            single[SP_W-2:0] = '0;
        end else begin
            // bias 3 to 127
            // Bit copy instead of an adder; same result as adding the bias difference
            single[SP_W-2] = exp3[RF_EXP_W-1];
            single[SP_FRAC_W+RF_EXP_W-1 +: SP_EXP_W-RF_EXP_W] = {(SP_EXP_W-RF_EXP_W){~exp3[RF_EXP_W-1]}};
            single[SP_FRAC_W +: RF_EXP_W-1] = exp3[RF_EXP_W-2:0];
            single[SP_FRAC_W-RF_FRAC_W +: RF_FRAC_W] = frac4;
        end
    end
endmodule

// ---- tb/otu_datapath_model.sv ----
// Datapath side of the unpacker: takes every answer and queues it in order.
// Assumes the answer stands for exactly one core_clk cycle.
`timescale 1ns/10ps
module otu_datapath_model
    import otu_pkg::*;
(
    input wire logic core_clk,
    input wire logic rst,
    input otu_resp_t resp
);
    otu_resp_t got[$];

    // Sampled every edge: like the real datapath, no ready, so a missed cycle loses data
    always @(posedge core_clk) begin
        if (rst) begin
            got.delete();
        end else if (resp.valid === 1'b1) begin
            got.push_back(resp);
        end
    end
endmodule

// ---- tb/operand_type_unpacker_tb.sv ----
// Self-checking bench for the operand type unpacker.
// Assumes one core_clk domain; requests driven on rising edges, answers queued by the datapath model.
`timescale 1ns/10ps
module operand_type_unpacker_tb
    import otu_pkg::*;
    ;
    localparam logic [127:0] ALL = '1;
    localparam logic [127:0] SGL = 128'hffffffff;
    localparam logic [127:0] DBL = 128'hffffffffffffffff;
    logic coreClk;
    logic rst;
    otu_req_t req;
    logic [31:0] ctrlZero;
    otu_resp_t resp;
    int nFail;
    int comparisons;

    operand_type_unpacker i_operand_type_unpacker (.core_clk(coreClk), .rst(rst), .req(req),
        .controlRegisterZero(ctrlZero), .resp(resp));
    otu_datapath_model i_otu_datapath_model (.core_clk(coreClk), .rst(rst), .resp(resp));

    initial begin
        coreClk = 1'b0;
        forever #2 coreClk = ~coreClk;
    end

    task automatic results();
        $display("comparisons %0d mismatches %0d", comparisons, nFail);
        if (nFail == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
        comparisons++;
        if (g !== e) begin
            nFail++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Bounded wait for the model to hold n answers
    task automatic waitGot(input int n);
        int k;
        k = 0;
        while (i_otu_datapath_model.got.size() < n && k < 8) begin
            @(posedge coreClk);
            k++;
        end
        if (k == 8) begin
            nFail++;
            $display("wrong value answer count expected %0d seen %0d", n, i_otu_datapath_model.got.size());
            results();
        end
    endtask

    task automatic tc(input string nm, input otu_type_t t, input logic [63:0] op, input logic [5:0] ee,
        input logic [127:0] ed, input logic [127:0] m = ALL, input logic [31:0] c = 32'h0,
        input otu_role_t ro = ROLE_IMMEDIATE, input otu_group_t g = GROUP_NONE,
        input logic [15:0] a = 16'h0, input logic rw = 1'b0);
        otu_resp_t r;
        @(posedge coreClk);
        ctrlZero <= c;
        req <= '{1'b1, t, ro, g, rw, a, op};
        @(posedge coreClk);
        req.valid <= 1'b0;
        #1;
        chk({nm, " valid"}, 128'h1, 128'(resp.valid));
        waitGot(1);
        #1;
        chk({nm, " cleared"}, 128'h0, 128'(resp.valid));
        r = i_otu_datapath_model.got.pop_front();
        chk({nm, " err"}, 128'(ee), 128'(r.err));
        chk(nm, ed & m, r.data & m);
    endtask

    function automatic logic [127:0] nib(input logic [31:0] op, input logic sg);
        logic [127:0] v;
        for (int i = 0; i < 8; i++) begin
            v[16*i +: 16] = {{12{sg & op[4*i+3]}}, op[4*i +: 4]};
        end
        return v;
    endfunction

    // Exponent rebias by 124, with zero codes kept apart
    function automatic logic [31:0] rf(input logic [7:0] c);
        if (c[6:0] == 7'h00) begin
            return {c[7], 31'h0};
        end
        return {c[7], c[6], {5{~c[6]}}, c[5:4], c[3:0], 19'h0};
    endfunction

    task automatic s_nibbles();
        tc("signed walk", TYPE_PACKED_SIGNED_NIBBLE_VECTOR, 64'hf0000008, 6'h00, nib(32'hf0000008, 1'b1));
        tc("signed mix", TYPE_PACKED_SIGNED_NIBBLE_VECTOR, 64'h7f8e1c69, 6'h00, nib(32'h7f8e1c69, 1'b1));
        tc("unsigned mix", TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR, 64'h7f8e1c69, 6'h00, nib(32'h7f8e1c69, 1'b0));
    endtask

    task automatic s_rfloat();
        tc("rf a", TYPE_PACKED_RESTRICTED_FLOAT_VECTOR, 64'h803f0170, 6'h00,
            {rf(8'h80), rf(8'h3f), rf(8'h01), rf(8'h70)});
        tc("rf b", TYPE_PACKED_RESTRICTED_FLOAT_VECTOR, 64'h00ff8f10, 6'h00,
            {rf(8'h00), rf(8'hff), rf(8'h8f), rf(8'h10)});
        tc("rf one", TYPE_PACKED_RESTRICTED_FLOAT_VECTOR, 64'h3f, 6'h00, 128'h3ff80000, SGL);
    endtask

    task automatic s_misuse();
        tc("nib src", TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR, 64'h1, 6'h08, 0, 0, 0, ROLE_SOURCE);
        tc("rf dst", TYPE_PACKED_RESTRICTED_FLOAT_VECTOR, 64'h1, 6'h08, 0, 0, 0, ROLE_DESTINATION);
        tc("nibble alone", TYPE_NIBBLE, 64'h5, 6'h10, 0);
        tc("byte dst", TYPE_UNSIGNED_BYTE, 64'h5a, 6'h04, 0, 0, 0, ROLE_DESTINATION);
        tc("raw byte dst", TYPE_UNSIGNED_BYTE, 64'h0123456789abcdef, 6'h00, 128'h0123456789abcdef, ALL, 0,
            ROLE_DESTINATION, GROUP_NONE, 16'h0, 1'b1);
    endtask

    task automatic s_align();
        logic [15:0] aa[11] = '{16'h1, 16'h2, 16'h2, 16'h4, 16'h4, 16'h8, 16'h8, 16'h10, 16'h10, 16'h20, 16'h1};
        otu_type_t t;
        otu_group_t g;
        for (int i = 0; i < 11; i++) begin
            t = (i < 2) ? TYPE_UNSIGNED_WORD : (i < 4) ? TYPE_SIGNED_DOUBLEWORD : TYPE_UNSIGNED_BYTE;
            g = (i >= 4 && i < 10) ? otu_group_t'((i - 2) / 2) : GROUP_NONE;
            tc("align", t, 64'h0, (i % 2 == 0 && i < 10) ? 6'h20 : 6'h00, 0, 0, 0, ROLE_SOURCE, g, aa[i]);
        end
    endtask

    task automatic s_ints();
        tc("sbyte", TYPE_SIGNED_BYTE, 64'hf0, 6'h00, 128'hfffffffffffffff0);
        tc("ubyte", TYPE_UNSIGNED_BYTE, 64'hf0, 6'h00, 128'hf0);
        tc("sword", TYPE_SIGNED_WORD, 64'h8001, 6'h00, 128'hffffffffffff8001);
        tc("uword", TYPE_UNSIGNED_WORD, 64'h8001, 6'h00, 128'h8001);
        tc("sdword", TYPE_SIGNED_DOUBLEWORD, 64'h80000000, 6'h00, 128'hffffffff80000000);
        tc("udword", TYPE_UNSIGNED_DOUBLEWORD, 64'h80000000, 6'h00, 128'h80000000);
    endtask

    task automatic s_float();
        tc("sp normal", TYPE_SINGLE_FLOAT, 64'h3fc00000, 6'h00, 128'h3fc00000, SGL);
        tc("sp denorm", TYPE_SINGLE_FLOAT, 64'h807fffff, 6'h00, 128'h80000000, SGL);
        tc("sp alternative inf", TYPE_SINGLE_FLOAT, 64'h7f800000, 6'h02, 128'h7f800000, SGL, 32'h1);
        tc("sp ieee inf", TYPE_SINGLE_FLOAT, 64'h7f800000, 6'h00, 128'h7f800000, SGL, 32'h2);
        tc("dp normal", TYPE_DOUBLE_PRECISION_FLOAT, 64'hc00921fb54442d18, 6'h00, 128'hc00921fb54442d18, DBL);
        tc("dp keep", TYPE_DOUBLE_PRECISION_FLOAT, 64'h800fffffffffffff, 6'h00, 128'h800fffffffffffff, DBL,
            32'h40);
        tc("dp flush", TYPE_DOUBLE_PRECISION_FLOAT, 64'h800fffffffffffff, 6'h00, 128'h8000000000000000, DBL);
        tc("dp alternative", TYPE_DOUBLE_PRECISION_FLOAT, 64'h3ff0000000000000, 6'h01, 0, 0, 32'h1);
    endtask

    // Requests on consecutive edges; valid held high across both
    task automatic s_b2b();
        otu_resp_t r;
        @(posedge coreClk);
        req <= '{1'b1, TYPE_PACKED_UNSIGNED_NIBBLE_VECTOR, ROLE_IMMEDIATE, GROUP_NONE, 1'b0, 16'h0, 64'h13579bdf};
        @(posedge coreClk);
        req.opType <= TYPE_PACKED_SIGNED_NIBBLE_VECTOR;
        req.operand <= 64'h02468ace;
        @(posedge coreClk);
        req.valid <= 1'b0;
        waitGot(2);
        r = i_otu_datapath_model.got.pop_front();
        chk("b2b first", nib(32'h13579bdf, 1'b0), r.data);
        r = i_otu_datapath_model.got.pop_front();
        chk("b2b second", nib(32'h02468ace, 1'b1), r.data);
    endtask

    initial begin
        rst = 1'b1;
        req = '0;
        ctrlZero = 32'h0;
        nFail = 0;
        comparisons = 0;
        repeat (2) @(posedge coreClk);
        rst <= 1'b0;
        @(posedge coreClk);
        #1;
        chk("reset valid", 128'h0, 128'(resp.valid));
        s_nibbles();
        s_rfloat();
        s_misuse();
        s_align();
        s_ints();
        s_float();
        s_b2b();
        results();
    end
endmodule
